// ==== rtl/dfa_defs.svh ====
/*
 * Constants of the deserializer and frame aligner: register byte offsets,
 * control field positions and reset values.
 * Assumes it is included once per compilation unit before the design.
 */
//
// Notes on behaviour
// - deserialize serial stream at 16, 10, 8, 4
// - ratio code selects centred active output lanes
// - pins set ratio unless register override set
// - register ratio defaults to sixteen bits
// - lsb on lowest active lane, swap reverses
// - parity even, odd when inverted, can disable
// - frame pulse lasts one parallel clock cycle
// - align enabled by pin or register pair
// - header match realigns boundary and pulses frame
// - mask bits exclude header bits from compare
// - 32-bit header resets to F6F62828
// - alignment off keeps boundary, pulses frame on match at boundary
// - 10-bit mode uses low ten bits of the 10-bit header register, masked by its bits 25:16
// - complement search matches pattern or its inverse
// - 10-bit header resets to comma pattern
// - arm on enable rise, disarm on pulse once enable low
// - boundary found on second A2 byte
// - first aligned word starts at first A2
// - mute forces zeros, driver disable separate
// - data invert, clock invert, clock enable
// - loopback pins select loop input or serial out
`ifndef DFA_DEFS_SVH
`define DFA_DEFS_SVH

`define DFA_CTRL_OFS 12'h000
`define DFA_HDR_OFS 12'h004
`define DFA_MSK_OFS 12'h008
`define DFA_STAT_OFS 12'h00c
`define DFA_H10_OFS 12'h010

`define DFA_C_RATIO 1
`define DFA_C_RATIO_OVR 2
`define DFA_C_SWAP 3
`define DFA_C_ALIGN_OVR 4
`define DFA_C_ALIGN_EN 5
`define DFA_C_COMPLEMENT_SEARCH 6
`define DFA_C_PAR_ODD 7
`define DFA_C_PAR_EN 8
`define DFA_C_MUTE 9
`define DFA_C_DRV_EN 10
`define DFA_C_DINV 11
`define DFA_C_CINV 12
`define DFA_C_CEN 13

`define DFA_CTRL_RST 14'h2503
`define DFA_HDR_RST 32'hf6f62828
`define DFA_MSK_RST 32'h00000000
`define DFA_H10_RST 32'h000000fa

`endif

// ==== rtl/dfa_pkg.sv ====
/*
 * Types of the deserializer and frame aligner.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dfa_pkg;

    typedef enum logic [1:0] {
        DFA_R4 = 2'h0,
        DFA_R8 = 2'h1,
        DFA_R10 = 2'h2,
        DFA_R16 = 2'h3
    } dfa_ratio_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [13:0] ctrl;
        logic [31:0] hdr;
        logic [31:0] msk;
        logic [31:0] h10;
        logic [15:0] fcount;
        logic [1:0] rclk_s;
        logic [1:0] rdat_s;
        logic [1:0] lclk_s;
        logic [1:0] ldat_s;
        logic [1:0] diag_s;
        logic [1:0] line_s;
        logic [1:0] rlo_s;
        logic [1:0] rhi_s;
        logic [1:0] aen_s;
        logic sclk_prev;
        logic [31:0] sh;
        logic [3:0] cnt;
        logic armed;
        logic aen_prev;
        logic [15:0] word_raw;
        logic fp_raw;
        logic [15:0] pout;
        logic poe;
        logic pclk;
        logic fp;
        logic fpn;
        logic par;
        logic parn;
        logic sclk_out;
        logic sdat_out;
    } dfa_state_t;

endpackage : dfa_pkg

// ==== rtl/dfa_top.sv ====
/*
 * Receive deserializer with programmable header detection and word
 * alignment, reached over APB.
 * Assumes the serial clock and data pins are slow enough for clk to
 * oversample them, and an APB master on clk.
 */
// Chosen here: the register offsets and the APB register port.
`include "dfa_defs.svh"

module dfa_top
    import dfa_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic recovered_clock_in,
    input wire logic recovered_data_in,
    input wire logic loop_clock_in,
    input wire logic loop_data_in,
    input wire logic diag_loopback_n,
    input wire logic line_loopback_n,
    input wire logic ratio_sel_pin_lo,
    input wire logic ratio_sel_pin_hi,
    input wire logic align_enable,
    output logic [15:0] parallel_word_out,
    output logic parallel_out_oe,
    output logic parallel_out_clock,
    output logic frame_pulse,
    output logic frame_pulse_n,
    output logic word_parity,
    output logic word_parity_n,
    output logic serial_clock_out,
    output logic serial_data_out
);

    localparam dfa_state_t ST_RST = '{
        ctrl: `DFA_CTRL_RST,
        hdr: `DFA_HDR_RST,
        msk: `DFA_MSK_RST,
        h10: `DFA_H10_RST,
        // active-low loopback pins idle high, so no loop mode shows after reset
        diag_s: 2'h3,
        line_s: 2'h3,
        fpn: 1'b1,
        parn: 1'b1,
        default: '0
    };

    logic [1:0] rst_sync;
    logic rst_n;
    dfa_state_t q;
    dfa_state_t n;

    logic sel_clk;
    logic sel_dat;
    logic bit_ev;
    logic [31:0] nsh;
    dfa_ratio_t ratio;
    logic [4:0] wid;
    logic [3:0] lo;
    logic [15:0] word16;
    // driven bit by bit from the lane loop, so nets rather than variables
    wire logic [15:0] mapped;
    wire logic [15:0] active;
    logic swap;
    logic ten;
    logic hit32;
    logic cmp32;
    logic hit10;
    logic cmp10;
    logic match;
    logic boundary;
    logic realign;
    logic word_ev;
    logic fp_ev;
    logic aen_eff;
    logic aen_rise;
    logic [15:0] bus;
    logic acc;
    logic done;
    logic addr_ok;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // lane mapping: lsb on the lowest active lane, unused lanes held low
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_lane
            logic [4:0] j;
            logic [4:0] k;
            logic in_lane;
            assign j = 5'(gi) - {1'b0, lo};
            assign k = wid - 5'h1 - j;
            assign in_lane = (5'(gi) >= {1'b0, lo}) && (j < wid);
            assign active[gi] = in_lane;
            assign mapped[gi] = in_lane ? word16[swap ? k[3:0] : j[3:0]] : 1'b0;
        end
    endgenerate

    always_comb begin
        n = q;
        sel_clk = 1'b0;
        sel_dat = 1'b0;
        ratio = DFA_R16;
        wid = 5'h10;
        lo = 4'h0;
        word16 = 16'h0;
        bus = 16'h0;

        // pin synchronisers: stage 0 feeds only stage 1
        n.rclk_s = {q.rclk_s[0], recovered_clock_in};
        n.rdat_s = {q.rdat_s[0], recovered_data_in};
        n.lclk_s = {q.lclk_s[0], loop_clock_in};
        n.ldat_s = {q.ldat_s[0], loop_data_in};
        n.diag_s = {q.diag_s[0], diag_loopback_n};
        n.line_s = {q.line_s[0], line_loopback_n};
        n.rlo_s = {q.rlo_s[0], ratio_sel_pin_lo};
        n.rhi_s = {q.rhi_s[0], ratio_sel_pin_hi};
        n.aen_s = {q.aen_s[0], align_enable};

        if (!q.diag_s[1]) begin
            sel_clk = q.lclk_s[1];
            sel_dat = q.ldat_s[1];
        end else begin
            sel_clk = q.rclk_s[1];
            sel_dat = q.rdat_s[1];
        end
        n.sclk_prev = sel_clk;
        bit_ev = sel_clk & ~q.sclk_prev;

        // line loopback repeats the recovered stream, otherwise outputs idle low
        n.sclk_out = ~q.line_s[1] & q.rclk_s[1];
        n.sdat_out = ~q.line_s[1] & q.rdat_s[1];

        if (q.ctrl[`DFA_C_RATIO_OVR]) begin
            ratio = dfa_ratio_t'(q.ctrl[`DFA_C_RATIO:0]);
        end else begin
            ratio = dfa_ratio_t'({q.rhi_s[1], q.rlo_s[1]});
        end
        swap = q.ctrl[`DFA_C_SWAP];
        ten = (ratio == DFA_R10);

        nsh = {q.sh[30:0], sel_dat};

        // the word starts at the first A2 byte of the matched header
        case (ratio)
            DFA_R4: begin
                wid = 5'h04;
                lo = 4'h6;
                word16 = {12'h0, nsh[15:12]};
            end
            DFA_R8: begin
                wid = 5'h08;
                lo = 4'h4;
                word16 = {8'h0, nsh[15:8]};
            end
            DFA_R10: begin
                wid = 5'h0a;
                lo = 4'h3;
                word16 = {6'h0, nsh[9:0]};
            end
            DFA_R16: begin
                wid = 5'h10;
                lo = 4'h0;
                word16 = nsh[15:0];
            end
            default: begin
                wid = 5'h10;
                lo = 4'h0;
                word16 = nsh[15:0];
            end
        endcase

        hit32 = ((nsh ^ q.hdr) & ~q.msk) == 32'h0;
        cmp32 = ((~nsh ^ q.hdr) & ~q.msk) == 32'h0;
        hit10 = ((nsh[9:0] ^ q.h10[9:0]) & ~q.h10[25:16]) == 10'h0;
        cmp10 = ((~nsh[9:0] ^ q.h10[9:0]) & ~q.h10[25:16]) == 10'h0;
        if (ten) begin
            match = hit10 | (q.ctrl[`DFA_C_COMPLEMENT_SEARCH] & cmp10);
        end else begin
            match = hit32 | (q.ctrl[`DFA_C_COMPLEMENT_SEARCH] & cmp32);
        end

        boundary = bit_ev && ({1'b0, q.cnt} >= wid - 5'h1);
        realign = bit_ev && q.armed && match;
        word_ev = boundary | realign;
        fp_ev = bit_ev && match && (q.armed || boundary);

        if (bit_ev) begin
            n.sh = nsh;
            if (word_ev) begin
                n.cnt = 4'h0;
            end else begin
                n.cnt = q.cnt + 4'h1;
            end
        end
        if (word_ev) begin
            n.word_raw = mapped;
            n.fp_raw = fp_ev;
        end
        if (fp_ev) begin
            n.fcount = q.fcount + 16'h1;
        end

        aen_eff = q.aen_s[1] | (q.ctrl[`DFA_C_ALIGN_OVR] & q.ctrl[`DFA_C_ALIGN_EN]);
        aen_rise = aen_eff & ~q.aen_prev;
        n.aen_prev = aen_eff;
        if (aen_rise) begin
            n.armed = 1'b1;
        end else if (!aen_eff && fp_ev) begin
            n.armed = 1'b0;
        end

        // output stage: data, frame pulse and parity move together
        bus = n.word_raw ^ (q.ctrl[`DFA_C_DINV] ? active : 16'h0);
        if (q.ctrl[`DFA_C_MUTE]) begin
            bus = 16'h0;
        end
        n.pout = bus;
        n.poe = q.ctrl[`DFA_C_DRV_EN];
        n.fp = n.fp_raw;
        n.fpn = ~n.fp_raw;
        if (q.ctrl[`DFA_C_PAR_EN]) begin
            n.par = ^bus ^ q.ctrl[`DFA_C_PAR_ODD];
            n.parn = ~n.par;
        end else begin
            n.par = 1'b0;
            n.parn = 1'b0;
        end
        // parallel clock rises with each new word, high for the first half
        n.pclk = q.ctrl[`DFA_C_CEN]
            & (({1'b0, n.cnt} < (wid >> 1)) ^ q.ctrl[`DFA_C_CINV]);

        // apb slave: one wait state, answer registered
        // unmapped offsets answer with an error and leave every register alone
        case (paddr)
            `DFA_CTRL_OFS: addr_ok = 1'b1;
            `DFA_HDR_OFS: addr_ok = 1'b1;
            `DFA_MSK_OFS: addr_ok = 1'b1;
            `DFA_STAT_OFS: addr_ok = 1'b1;
            `DFA_H10_OFS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
        acc = psel & penable & ~q.pready;
        done = psel & penable & q.pready;
        n.pready = acc;
        n.pslverr = acc & ~addr_ok;
        if (acc && !pwrite) begin
            case (paddr)
                `DFA_CTRL_OFS: n.prdata = {18'h0, q.ctrl};
                `DFA_HDR_OFS: n.prdata = q.hdr;
                `DFA_MSK_OFS: n.prdata = q.msk;
                `DFA_STAT_OFS: n.prdata = {q.fcount, 12'h0, q.armed, aen_eff, ratio};
                `DFA_H10_OFS: n.prdata = {6'h0, q.h10[25:16], 6'h0, q.h10[9:0]};
                default: n.prdata = 32'h0;
            endcase
        end
        if (done && pwrite && !q.pslverr) begin
            case (paddr)
                `DFA_CTRL_OFS: n.ctrl = pwdata[13:0];
                `DFA_HDR_OFS: n.hdr = pwdata;
                `DFA_MSK_OFS: n.msk = pwdata;
                `DFA_H10_OFS: n.h10 = {6'h0, pwdata[25:16], 6'h0, pwdata[9:0]};
                default: n.h10 = q.h10;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign parallel_word_out = q.pout;
    assign parallel_out_oe = q.poe;
    assign parallel_out_clock = q.pclk;
    assign frame_pulse = q.fp;
    assign frame_pulse_n = q.fpn;
    assign word_parity = q.par;
    assign word_parity_n = q.parn;
    assign serial_clock_out = q.sclk_out;
    assign serial_data_out = q.sdat_out;

endmodule : dfa_top

// ==== bench/dfa_checker.sv ====
/* Port checker of the deserializer: APB answer, frame and parity pairs,
   line loopback. Assumes it is bound to dfa_top. */
module dfa_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic recovered_clock_in,
    input wire logic line_loopback_n,
    input wire logic frame_pulse,
    input wire logic frame_pulse_n,
    input wire logic word_parity,
    input wire logic word_parity_n,
    input wire logic serial_clock_out,
    input wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    rdy_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    rdy_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    err_rdy_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    fp_pair_a: assert property (frame_pulse_n == !frame_pulse)
        else $error("frame pair split");
    fp_hold_a: assert property ($rose(frame_pulse) |=> frame_pulse[*8])
        else $error("frame pulse short");
    par_pair_a: assert property (!(word_parity && word_parity_n))
        else $error("parity pair both high");
    lbk_idle_a: assert property (line_loopback_n[*5] |-> !serial_clock_out && !serial_data_out)
        else $error("serial out not idle");
    lbk_copy_a: assert property (!line_loopback_n && $rose(recovered_clock_in)
        |-> ##[1:5] (serial_clock_out || line_loopback_n))
        else $error("serial clock not looped");
    cover property ($rose(frame_pulse));
    cover property (pslverr);
    cover property ($rose(serial_clock_out));
endmodule : dfa_checker

// ==== bench/dfa_far_end.sv ====
/* Far side: serial source of recovered clock and data, and the framing
   device's align enable. Its clock stands still between frames. */
module dfa_far_end (
    output logic sclk,
    output logic sdat,
    output logic aen
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk = 1'b0;
        sdat = 1'b0;
        aen = 1'b0;
        // raised at 3137 ns and held high from then on so alignment can be verified
        #3137 aen = 1'b1;
    end
    task send(input logic [31:0] bits, input int n);
        #37;
        for (int i = n - 1; i >= 0; i--) begin
            sdat = bits[i];
            #400 sclk = 1'b1;
            #400 sclk = 1'b0;
        end
        // released line must not show the last bit
        sdat = ~sdat;
    endtask : send
endmodule : dfa_far_end

// ==== bench/testbench.sv ====
/* Bench of dfa_top: APB register checks and framed serial traffic.
   Assumes the far-end model drives the recovered stream. */
`include "dfa_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic line_loopback_n = 1'b0;
    logic rlo = 1'b1;
    logic rhi = 1'b1;
    logic diag_n = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, oe, fp, fpn, par, sclk, sdat, aen, pclk;
    logic [15:0] word;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    dfa_top i_dfa_top (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .recovered_clock_in(sclk & diag_n), .recovered_data_in(sdat),
        .loop_clock_in(sclk & ~diag_n), .loop_data_in(sdat), .diag_loopback_n(diag_n),
        .line_loopback_n(line_loopback_n), .ratio_sel_pin_lo(rlo), .ratio_sel_pin_hi(rhi),
        .align_enable(aen), .parallel_word_out(word), .parallel_out_oe(oe),
        .parallel_out_clock(pclk), .frame_pulse(fp), .frame_pulse_n(fpn), .word_parity(par),
        .word_parity_n(), .serial_clock_out(), .serial_data_out());
    dfa_far_end i_dfa_far_end (.sclk(sclk), .sdat(sdat), .aen(aen));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            miscompares++;
            final_report;
        end
    end
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0);
        chk("prdata", x, q);
        chk("pslverr", {31'h0, xe}, {31'h0, e});
    endtask : rd
    task run(input logic [31:0] c, input logic [31:0] m, input logic [31:0] p, input int n,
        input logic [15:0] w);
        apb(1'b1, `DFA_CTRL_OFS, c);
        apb(1'b1, `DFA_MSK_OFS, m);
        i_dfa_far_end.send(32'h0, 16);
        i_dfa_far_end.send(p, n);
        for (int i = 0; i < 40 && fp !== 1'b1; i++) begin
            @(posedge clk);
        end
        chk("frame_pulse", 32'h1, {31'h0, fp});
        chk("frame_pulse_n", 32'h0, {31'h0, fpn});
        chk("word", {16'h0, w}, {16'h0, word});
        chk("parity", {31'h0, ^w ^ c[7]}, {31'h0, par});
    endtask : run
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`DFA_CTRL_OFS, 32'h2503, 1'b0);
        rd(`DFA_HDR_OFS, 32'hf6f62828, 1'b0);
        rd(`DFA_MSK_OFS, 32'h0, 1'b0);
        rd(`DFA_H10_OFS, 32'h0fa, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        run(32'h2503, 32'hff, 32'hf6f62855, 32, 16'h2855);
        rd(`DFA_STAT_OFS, 32'h0001000f, 1'b0);
        line_loopback_n <= 1'b1;
        run(32'h2585, 32'h0, 32'hf6f62828, 32, 16'h0280);
        run(32'h2546, 32'h0, 32'h305, 10, 16'h1828);
        run(32'h250f, 32'h0, 32'hf6f62828, 32, 16'h1414);
        // four-bit words from the ratio pins, serial clock only on the loop inputs
        @(posedge clk);
        rlo <= 1'b0;
        rhi <= 1'b0;
        diag_n <= 1'b0;
        run(32'h2500, 32'h0, 32'hf6f62828, 32, 16'h0080);
        chk("out clock", 32'h1, {31'h0, pclk});
        apb(1'b1, `DFA_CTRL_OFS, 32'h3303);
        repeat (3) @(posedge clk);
        chk("muted word", 32'h0, {16'h0, word});
        chk("driver enable", 32'h0, {31'h0, oe});
        chk("out clock", 32'h0, {31'h0, pclk});
        final_report;
    end
endmodule : testbench
bind dfa_top dfa_checker i_dfa_checker (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .recovered_clock_in(recovered_clock_in), .line_loopback_n(line_loopback_n),
    .frame_pulse(frame_pulse), .frame_pulse_n(frame_pulse_n), .word_parity(word_parity),
    .word_parity_n(word_parity_n), .serial_clock_out(serial_clock_out),
    .serial_data_out(serial_data_out));
